// file: design/tcmc_defines.vh
// Register offsets, field positions and reset values
// for the timer count-mode control block.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef TCMC_DEFINES_VH
`define TCMC_DEFINES_VH

// Register byte offsets
`define TCMC_OFF_CTRL        12'h000
`define TCMC_OFF_RELOAD      12'h004
`define TCMC_OFF_COUNT       12'h008
`define TCMC_OFF_CMP         12'h00C
`define TCMC_OFF_EVENT       12'h010
`define TCMC_OFF_STATUS      12'h014
`define TCMC_OFF_MASK        12'h018
`define TCMC_OFF_ACTRELOAD   12'h01C

// Control register field positions
`define TCMC_CTRL_RUN        0
`define TCMC_CTRL_SINGLE     3
`define TCMC_CTRL_DIR        4
`define TCMC_CTRL_ALIGN_LO   5
`define TCMC_CTRL_ALIGN_HI   6
`define TCMC_CTRL_RBUF       7

// Compare register fields
`define TCMC_CMP_VAL_HI      15
`define TCMC_CMP_ROLE_LO     16
`define TCMC_CMP_ROLE_HI     17

// Event register: software update request; the trigger start bit is defined but not decoded
`define TCMC_EVT_UPDATE      0
`define TCMC_EVT_TRIGGER     1

// Status register bits
`define TCMC_ST_UPDATE       0
`define TCMC_ST_COMPARE      1

// Alignment encodings
`define TCMC_ALIGN_EDGE      2'h0
`define TCMC_ALIGN_CTR1      2'h1
`define TCMC_ALIGN_CTR2      2'h2
`define TCMC_ALIGN_CTR3      2'h3

// Channel role: compare output
`define TCMC_ROLE_OUTPUT     2'h0

// Reset values
`define TCMC_RST_CTRL        8'h00
`define TCMC_RST_RELOAD      16'hFFFF
`define TCMC_RST_CMP         18'h0_0000
`define TCMC_RST_MASK        2'h0

// Counter width
`define TCMC_CNT_W           16

`endif

// file: design/tcmc_apb_slave.v
// APB slave front end: decodes a completed access into one-cycle strobes.
// Assumes an APB master on the same clock; zero wait states.
`timescale 1ns/10ps
`default_nettype none

module tcmc_apb_slave (
    // Clock and reset
    input  wire        ref_clk_i,
    input  wire        rst_i,
    // APB
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    output wire        pready_o,
    output wire        pslverr_o,
    // Decoded access
    output wire        wr_o,
    output wire        rd_o,
    output wire [11:0] addr_o,
    input  wire        unmapped_i
);

    ////////////////////////////////////////////////////////////////////
    // Access phase completes in one cycle; unmapped gives an error
    assign pready_o  = psel_i & penable_i;
    assign pslverr_o = psel_i & penable_i & unmapped_i;
    assign wr_o      = psel_i & penable_i & pwrite_i & ~unmapped_i;
    assign rd_o      = psel_i & penable_i & ~pwrite_i;
    assign addr_o    = {paddr_i[11:2], 2'b00};

endmodule // tcmc_apb_slave

`default_nettype wire

// file: design/tcmc_irq.v
// Sticky status bits with write-one-to-clear, mask, level interrupt.
// Assumes event pulses on the same clock; set wins over clear.
`include "tcmc_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module tcmc_irq (
    // Clock and reset
    input  wire       ref_clk_i,
    input  wire       rst_i,
    // Events and software access
    input  wire [1:0] event_i,
    input  wire [1:0] clear_i,
    input  wire       mask_wr_i,
    input  wire [1:0] mask_wdata_i,
    // Results
    output wire [1:0] status_o,
    output wire [1:0] mask_o,
    output wire       irq_o
);

    reg [1:0] status_q;
    reg [1:0] mask_q;

    ////////////////////////////////////////////////////////////////////
    // Status and mask registers
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_q <= 2'h0;
            mask_q   <= `TCMC_RST_MASK;
        end else begin
            status_q <= (status_q & ~clear_i) | event_i;
            if (mask_wr_i) begin
                mask_q <= mask_wdata_i;
            end
        end
    end

    // Level interrupt while any unmasked bit is set
    assign status_o = status_q;
    assign mask_o   = mask_q;
    assign irq_o    = |(status_q & mask_q);

endmodule // tcmc_irq

`default_nettype wire

// file: design/tcmc_top.v
// Timer count-mode control: control register, counter, compare channel.
// Assumes an APB master on ref_clk_i and an external trigger pin.
//
// Decided for this implementation: the address map and register access over APB.
`include "tcmc_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module tcmc_top (
    // Clock and reset
    input  wire        ref_clk_i,
    input  wire        rst_i,
    // APB slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    // External trigger and slave reset pins
    input  wire        trigger_i,
    input  wire        slave_reset_i,
    // Timer outputs
    output reg         update_event_o,
    output reg         compare_out_o,
    output wire        irq_o
);

    ////////////////////////////////////////////////////////////////////
    // Declarations
    reg  [7:0]  ctrl_q;
    reg  [15:0] reload_value_q;      // Buffer written by software
    reg  [15:0] reload_active_q;     // Shadow used by the counter
    reg  [15:0] count_q;
    reg  [17:0] cmp_q;
    reg         dir_hw_q;            // Hardware direction in centre modes
    reg  [1:0]  trig_sync_q;
    reg  [1:0]  srst_sync_q;
    reg         trig_prev_q;
    reg         compare_out_d;
    reg         dir_gate;

    wire        bus_wr;
    wire        bus_rd;
    wire [11:0] bus_addr;
    wire        unmapped;
    wire [1:0]  status;
    wire [1:0]  mask;

    wire        reload_buffer_enable;
    wire [1:0]  count_alignment_select;
    wire        count_direction;
    wire        single_shot_select;
    wire        counter_run;
    wire [1:0]  channel_role_select;
    wire        centre_mode;
    wire        counting_down;
    wire        trig_rise;
    wire        sw_update;
    wire        slave_reset;
    wire        wrap_up;
    wire        wrap_down;
    wire        update_event;
    wire        match;
    wire        compare_flag;
    wire        ctrl_wr;
    wire        shot_stop;
    wire        reinit;
    wire [15:0] count_start;

    // Register write strobe for a given offset
    function wr_hit;
        input        wr;
        input [11:0] addr;
        input [11:0] off;
        begin
            wr_hit = wr & (addr == off);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // APB front end and interrupt logic
    // Zero wait states: each access completes in its first access cycle
    tcmc_apb_slave u_apb (
        .ref_clk_i  (ref_clk_i),
        .rst_i      (rst_i),
        .psel_i     (psel_i),
        .penable_i  (penable_i),
        .pwrite_i   (pwrite_i),
        .paddr_i    (paddr_i),
        .pready_o   (pready_o),
        .pslverr_o  (pslverr_o),
        .wr_o       (bus_wr),
        .rd_o       (bus_rd),
        .addr_o     (bus_addr),
        .unmapped_i (unmapped)
    );

    // Status bit 1 flags a compare, bit 0 an update event
    tcmc_irq u_irq (
        .ref_clk_i    (ref_clk_i),
        .rst_i        (rst_i),
        .event_i      ({compare_flag, update_event}),
        .clear_i      (wr_hit(bus_wr, bus_addr, `TCMC_OFF_STATUS) ? pwdata_i[1:0] : 2'h0),
        .mask_wr_i    (wr_hit(bus_wr, bus_addr, `TCMC_OFF_MASK)),
        .mask_wdata_i (pwdata_i[1:0]),
        .status_o     (status),
        .mask_o       (mask),
        .irq_o        (irq_o)
    );

    // Address map check
    // Anything past the last register answers with an error, not an alias
    assign unmapped = (paddr_i[11:2] > `TCMC_OFF_ACTRELOAD >> 2);

    ////////////////////////////////////////////////////////////////////
    // Field extraction
    assign reload_buffer_enable   = ctrl_q[`TCMC_CTRL_RBUF];
    assign count_alignment_select = ctrl_q[`TCMC_CTRL_ALIGN_HI:`TCMC_CTRL_ALIGN_LO];
    assign count_direction        = ctrl_q[`TCMC_CTRL_DIR];
    assign single_shot_select     = ctrl_q[`TCMC_CTRL_SINGLE];
    assign counter_run            = ctrl_q[`TCMC_CTRL_RUN];
    assign channel_role_select    = cmp_q[`TCMC_CMP_ROLE_HI:`TCMC_CMP_ROLE_LO];
    assign centre_mode            = (count_alignment_select != `TCMC_ALIGN_EDGE);
    assign ctrl_wr                = wr_hit(bus_wr, bus_addr, `TCMC_OFF_CTRL);

    // Edge-aligned follows the direction bit, centre follows hardware
    // One direction signal serves the wraps and the compare gate
    assign counting_down = centre_mode ? dir_hw_q : count_direction;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: second stage alone feeds logic
    // The edge flop idles low like the pin, so reset leaves no false edge
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            trig_sync_q <= 2'b00;
            srst_sync_q <= 2'b00;
            trig_prev_q <= 1'b0;
        end else begin
            trig_sync_q <= {trig_sync_q[0], trigger_i};
            srst_sync_q <= {srst_sync_q[0], slave_reset_i};
            trig_prev_q <= trig_sync_q[1];
        end
    end

    assign trig_rise   = trig_sync_q[1] & ~trig_prev_q;
    assign slave_reset = srst_sync_q[1];

    ////////////////////////////////////////////////////////////////////
    // Update event sources
    assign sw_update = wr_hit(bus_wr, bus_addr, `TCMC_OFF_EVENT) & pwdata_i[`TCMC_EVT_UPDATE];
    // Up wraps at or above reload, so a lowered reload is never overrun
    assign wrap_up   = counter_run & ~counting_down & (count_q >= reload_active_q);
    assign wrap_down = counter_run & counting_down & (count_q == 16'h0000);
    assign update_event = wrap_up | wrap_down | sw_update | slave_reset;

    // Software request and slave reset restart the count from its start
    assign reinit      = sw_update | slave_reset;
    assign count_start = (counting_down & ~centre_mode) ? reload_active_q : 16'h0000;

    // Single shot ends on any update event; the stop outranks a software write
    assign shot_stop = single_shot_select & update_event & counter_run;

    ////////////////////////////////////////////////////////////////////
    // Compare match gated by count direction for output channels in CTR1 and CTR2 alignment
    // A stopped counter raises no compare flag
    assign match = counter_run & (count_q == cmp_q[`TCMC_CMP_VAL_HI:0]);

    // Only output channels are gated; other roles flag every match
    always @* begin
        dir_gate = 1'b1;
        if (channel_role_select == `TCMC_ROLE_OUTPUT) begin
            case (count_alignment_select)
                `TCMC_ALIGN_EDGE: dir_gate = 1'b1;
                `TCMC_ALIGN_CTR1: dir_gate = counting_down;
                `TCMC_ALIGN_CTR2: dir_gate = ~counting_down;
                `TCMC_ALIGN_CTR3: dir_gate = 1'b1;
                default:          dir_gate = 1'b1;
            endcase
        end
    end

    assign compare_flag = match & dir_gate;

    ////////////////////////////////////////////////////////////////////
    // Control register: software writes, hardware run set and clear
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= `TCMC_RST_CTRL;
        end else begin
            if (ctrl_wr) begin
                ctrl_q[`TCMC_CTRL_RBUF]     <= pwdata_i[`TCMC_CTRL_RBUF];
                ctrl_q[`TCMC_CTRL_ALIGN_HI:`TCMC_CTRL_ALIGN_LO] <=
                    pwdata_i[`TCMC_CTRL_ALIGN_HI:`TCMC_CTRL_ALIGN_LO];
                ctrl_q[`TCMC_CTRL_SINGLE]   <= pwdata_i[`TCMC_CTRL_SINGLE];
                // Bits 2:1 are not held here and always read zero
                ctrl_q[2:1]                 <= 2'b00;
                // Direction bit accepts writes only when the written alignment field selects edge-aligned mode
                if (pwdata_i[`TCMC_CTRL_ALIGN_HI:`TCMC_CTRL_ALIGN_LO] == `TCMC_ALIGN_EDGE) begin
                    ctrl_q[`TCMC_CTRL_DIR] <= pwdata_i[`TCMC_CTRL_DIR];
                end
            end
            // Run bit: software, trigger start, single-shot stop
            // Stop outranks trigger start, which outranks a software write
            if (shot_stop) begin
                ctrl_q[`TCMC_CTRL_RUN] <= 1'b0;
            end else if (trig_rise) begin
                ctrl_q[`TCMC_CTRL_RUN] <= 1'b1;
            end else if (ctrl_wr) begin
                ctrl_q[`TCMC_CTRL_RUN] <= pwdata_i[`TCMC_CTRL_RUN];
            end
            // Direction bit mirrors hardware direction in centre modes
            if (centre_mode & ~ctrl_wr) begin
                ctrl_q[`TCMC_CTRL_DIR] <= dir_hw_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reload buffer and active shadow
    // A buffered write waits for the next update, a direct one lands now
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reload_value_q  <= `TCMC_RST_RELOAD;
            reload_active_q <= `TCMC_RST_RELOAD;
        end else begin
            if (wr_hit(bus_wr, bus_addr, `TCMC_OFF_RELOAD)) begin
                reload_value_q <= pwdata_i[15:0];
                if (!reload_buffer_enable) begin
                    reload_active_q <= pwdata_i[15:0];
                end
            end else if (update_event) begin
                reload_active_q <= reload_value_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Counter and hardware direction
    // A count write outranks a restart, which outranks plain counting
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_q  <= 16'h0000;
            dir_hw_q <= 1'b0;
        end else begin
            if (wr_hit(bus_wr, bus_addr, `TCMC_OFF_COUNT)) begin
                count_q <= pwdata_i[15:0];
            end else if (reinit) begin
                // Reinitialise to the start of the count
                count_q  <= count_start;
                dir_hw_q <= 1'b0;
            end else if (shot_stop) begin
                // Single shot: wrap then hold, ready to run from the start
                count_q  <= count_start;
                dir_hw_q <= 1'b0;
            end else if (counter_run) begin
                if (!centre_mode) begin
                    if (!counting_down) begin
                        count_q <= wrap_up ? 16'h0000 : count_q + 16'h0001;
                    end else begin
                        count_q <= wrap_down ? reload_active_q : count_q - 16'h0001;
                    end
                end else begin
                    // Centre-aligned: turn at the top and the bottom; each turn
                    // is the overflow or underflow that raises an update event
                    if (!dir_hw_q) begin
                        if (wrap_up) begin
                            dir_hw_q <= 1'b1;
                        end
                        count_q <= wrap_up ? count_q - 16'h0001 : count_q + 16'h0001;
                    end else begin
                        if (wrap_down) begin
                            dir_hw_q <= 1'b0;
                        end
                        count_q <= wrap_down ? 16'h0001 : count_q - 16'h0001;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Compare register and output reference
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmp_q <= `TCMC_RST_CMP;
        end else if (wr_hit(bus_wr, bus_addr, `TCMC_OFF_CMP)) begin
            cmp_q <= pwdata_i[17:0];
        end
    end

    // Output high while count is below compare value
    // Registered so the pin cannot glitch while the count settles
    always @* begin
        compare_out_d = (count_q < cmp_q[`TCMC_CMP_VAL_HI:0]);
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            compare_out_o  <= 1'b0;
            update_event_o <= 1'b0;
        end else begin
            compare_out_o  <= compare_out_d;
            update_event_o <= update_event;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data mux
    // Unmapped offsets fall to the default and read as zero
    always @* begin
        prdata_o = 32'h0000_0000;
        if (bus_rd) begin
            case (bus_addr)
                `TCMC_OFF_CTRL:      prdata_o = {24'h00_0000, ctrl_q};
                `TCMC_OFF_RELOAD:    prdata_o = {16'h0000, reload_value_q};
                `TCMC_OFF_COUNT:     prdata_o = {16'h0000, count_q};
                `TCMC_OFF_CMP:       prdata_o = {14'h0000, cmp_q};
                `TCMC_OFF_STATUS:    prdata_o = {30'h0000_0000, status};
                `TCMC_OFF_MASK:      prdata_o = {30'h0000_0000, mask};
                `TCMC_OFF_ACTRELOAD: prdata_o = {16'h0000, reload_active_q};
                default:             prdata_o = 32'h0000_0000;
            endcase
        end
    end

endmodule // tcmc_top

`default_nettype wire

// file: verification/tcmc_asserts.sv
// Concurrent checks on the timer count-mode control block.
// Sees only the top module's ports; attached by the bind at the foot.
`include "tcmc_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module tcmc_asserts (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    // APB
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Timer pins
    input wire logic        slave_reset_i,
    input wire logic        update_event_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // Access phase qualifiers
    wire acc    = psel_i && penable_i;
    wire wr_ctl = acc && pwrite_i && paddr_i == `TCMC_OFF_CTRL;
    wire rd_ctl = acc && !pwrite_i && paddr_i == `TCMC_OFF_CTRL;

    a_ready_access: assert property (pready_o == acc)
        else $error("pready differs from psel and penable");
    a_err_range: assert property (pslverr_o == (acc && paddr_i[11:2] > 10'h007))
        else $error("pslverr wrong for this address");
    a_rdata_idle: assert property (!(acc && !pwrite_i) |-> prdata_o == 32'h0000_0000)
        else $error("read data not zero outside a read access");
    a_err_zero: assert property (acc && !pwrite_i && pslverr_o |-> prdata_o == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_ctrl_fixed: assert property (rd_ctl |-> prdata_o[31:8] == 24'h00_0000 && !prdata_o[2:1])
        else $error("unused control bits read nonzero");
    a_ctrl_back: assert property (
        (wr_ctl && pwdata_i[6:5] == 2'h0 ##3 rd_ctl) |-> prdata_o[7:3] == $past(pwdata_i[7:3], 3))
        else $error("control fields did not read back");
    a_mask_quiet: assert property (
        acc && pwrite_i && paddr_i == `TCMC_OFF_MASK && pwdata_i[1:0] == 2'h0 |=> !irq_o)
        else $error("interrupt high with all events masked");
    a_slave_upd: assert property (slave_reset_i [*4] |-> ##[0:4] update_event_o)
        else $error("slave reset gave no update event");
endmodule // tcmc_asserts

bind tcmc_top tcmc_asserts u_chk (.ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .slave_reset_i,
    .update_event_o, .irq_o);

`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the timer count-mode control block.
// Drives APB, trigger and slave reset pins directly; checker is bound.
`include "tcmc_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic        ref_clk_i, rst_i, psel_i, penable_i, pwrite_i;
    logic        trigger_i, slave_reset_i, err;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, rd;
    wire  [31:0] prdata_o;
    wire         pready_o, pslverr_o, update_event_o, compare_out_o, irq_o;
    int          n_fail, compares;

    // Device under test
    tcmc_top uut (.ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .trigger_i, .slave_reset_i,
        .update_event_o, .compare_out_o, .irq_o);

    // 10 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // One APB transfer; the answer is taken at the edge that sees pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk_i);
            if (pready_o === 1'b1) break;
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (i == 50) begin
            n_fail++;
            end_of_test();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rd, exp);
    endtask

    // Bounded wait for an update pulse
    task automatic wait_upd;
        int i;
        for (i = 0; i < 2000; i++) begin
            @(negedge ref_clk_i);
            if (update_event_o === 1'b1) break;
        end
        if (i == 2000) begin
            n_fail++;
            end_of_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int          a;
        logic [31:0] r;
        logic [15:0] v;
        {psel_i, penable_i, pwrite_i, trigger_i, slave_reset_i} = 5'h00;
        paddr_i = 12'h000;
        pwdata_i = 32'h0000_0000;
        rst_i = 1'b1;
        n_fail = 0;
        compares = 0;
        r = $urandom(26800);
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rdc("ctrl_rst", `TCMC_OFF_CTRL, 32'h0000_0000);
        rdc("reload_rst", `TCMC_OFF_RELOAD, 32'h0000_FFFF);
        rdc("active_rst", `TCMC_OFF_ACTRELOAD, 32'h0000_FFFF);
        rdc("mask_rst", `TCMC_OFF_MASK, 32'h0000_0000);
        rdc("status_rst", `TCMC_OFF_STATUS, 32'h0000_0000);
        r = $urandom;
        apb(1'b1, 12'h020 + {r[7:0], 2'b00}, r);
        chk("wr_unmapped", err, 32'h0000_0001);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        chk("rd_unmapped_err", err, 32'h0000_0001);
        chk("rd_unmapped", rd, 32'h0000_0000);
        $display("test reset and map done");
        // Random control values, edge-aligned and stopped
        for (a = 0; a < 8; a++) begin
            r = $urandom & 32'hFFFF_FF9E;
            wr(`TCMC_OFF_CTRL, r);
            rdc("ctrl_rb", `TCMC_OFF_CTRL, r & 32'h0000_0098);
        end
        // Reload buffering and software update
        v = $urandom;
        wr(`TCMC_OFF_CTRL, 32'h0000_0000);
        wr(`TCMC_OFF_RELOAD, {16'h0000, v});
        rdc("act_direct", `TCMC_OFF_ACTRELOAD, {16'h0000, v});
        wr(`TCMC_OFF_CTRL, 32'h0000_0080);
        wr(`TCMC_OFF_RELOAD, {16'h0000, ~v});
        rdc("act_held", `TCMC_OFF_ACTRELOAD, {16'h0000, v});
        wr(`TCMC_OFF_EVENT, 32'h0000_0001);
        rdc("act_loaded", `TCMC_OFF_ACTRELOAD, {16'h0000, ~v});
        $display("test control and reload done");
        // Single shot up then down, then free running
        wr(`TCMC_OFF_CTRL, 32'h0000_0000);
        wr(`TCMC_OFF_RELOAD, 32'h0000_0005);
        for (a = 0; a < 2; a++) begin
            wr(`TCMC_OFF_COUNT, a ? 32'h0000_0003 : 32'h0000_0000);
            wr(`TCMC_OFF_CTRL, a ? 32'h0000_0019 : 32'h0000_0009);
            wait_upd();
            rdc("shot_ctrl", `TCMC_OFF_CTRL, a ? 32'h0000_0018 : 32'h0000_0008);
            rdc("shot_cnt", `TCMC_OFF_COUNT, a ? 32'h0000_0005 : 32'h0000_0000);
        end
        wr(`TCMC_OFF_CTRL, 32'h0000_0001);
        wait_upd();
        wait_upd();
        rdc("free_run", `TCMC_OFF_CTRL, 32'h0000_0001);
        $display("test single shot done");
        // Compare flag gating per alignment, rising pass, then falling pass in centre modes
        for (a = 0; a < 4; a++) begin
            wr(`TCMC_OFF_CTRL, 32'h0000_0000);
            wr(`TCMC_OFF_RELOAD, 32'd200);
            wr(`TCMC_OFF_CMP, 32'd4);
            wr(`TCMC_OFF_COUNT, 32'h0000_0000);
            wr(`TCMC_OFF_STATUS, 32'h0000_0003);
            wr(`TCMC_OFF_CTRL, (a << 5) | 1);
            repeat (12) @(posedge ref_clk_i);
            wr(`TCMC_OFF_CTRL, (a << 5) | (a ? 32'h10 : 32'h0));
            apb(1'b0, `TCMC_OFF_STATUS, 32'h0000_0000);
            chk("cmp_up", rd[1], a != 1);
            chk("pin_up", compare_out_o, 32'h0000_0000);
            rdc("dir_up", `TCMC_OFF_CTRL, a << 5);
            wr(`TCMC_OFF_CMP, 32'd190);
            wr(`TCMC_OFF_COUNT, 32'd195);
            wr(`TCMC_OFF_STATUS, 32'h0000_0003);
            wr(`TCMC_OFF_CTRL, (a << 5) | 1);
            repeat (30) @(posedge ref_clk_i);
            wr(`TCMC_OFF_CTRL, a << 5);
            apb(1'b0, `TCMC_OFF_STATUS, 32'h0000_0000);
            chk("cmp_down", rd[1], a == 1 || a == 3);
            chk("pin_down", compare_out_o, 32'h0000_0001);
            apb(1'b0, `TCMC_OFF_CTRL, 32'h0000_0000);
            chk("dir_down", rd[4], a != 0);
        end
        $display("test compare gating done");
        // Interrupt raise, clear and mask
        wr(`TCMC_OFF_MASK, 32'h0000_0002);
        @(negedge ref_clk_i);
        chk("irq_on", irq_o, 32'h0000_0001);
        wr(`TCMC_OFF_STATUS, 32'h0000_0002);
        @(negedge ref_clk_i);
        chk("irq_clr", irq_o, 32'h0000_0000);
        rdc("status_w1c", `TCMC_OFF_STATUS, 32'h0000_0001);
        wr(`TCMC_OFF_MASK, 32'h0000_0001);
        @(negedge ref_clk_i);
        chk("irq_upd", irq_o, 32'h0000_0001);
        wr(`TCMC_OFF_MASK, 32'h0000_0000);
        @(negedge ref_clk_i);
        chk("irq_mask", irq_o, 32'h0000_0000);
        $display("test interrupt done");
        // Slave reset and trigger start
        wr(`TCMC_OFF_CTRL, 32'h0000_0000);
        wr(`TCMC_OFF_COUNT, 32'd77);
        slave_reset_i <= 1'b1;
        wait_upd();
        repeat (4) @(posedge ref_clk_i);
        slave_reset_i <= 1'b0;
        rdc("slave_cnt", `TCMC_OFF_COUNT, 32'h0000_0000);
        trigger_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        rdc("trig_run", `TCMC_OFF_CTRL, 32'h0000_0001);
        trigger_i <= 1'b0;
        wr(`TCMC_OFF_CTRL, 32'h0000_0000);
        $display("test pins done");
        end_of_test();
    end
endmodule // tb_top

`default_nettype wire
